/* File: rtl/logger_cfg.svh */
// Address map, identification code fields and CRC constants for the logger memory block.
`ifndef LOGGER_CFG_SVH
`define LOGGER_CFG_SVH
`define ADDR_SRAM_LO 16'h0000
`define ADDR_SRAM_HI 16'h01BF
`define ADDR_SIG_LO 16'h01C0
`define ADDR_SIG_HI 16'h01FF
`define ADDR_REG_LO 16'h0200
`define ADDR_REG_HI 16'h023F
`define ADDR_CAL_LO 16'h0240
`define ADDR_CAL_HI 16'h027F
`define ADDR_RSV_LO 16'h0280
`define ADDR_RSV_HI 16'h0FFF
`define ADDR_LOG_LO 16'h1000
`define ADDR_LOG_HI 16'h2FFF
`define ADDR_PW_READ 16'h0227
`define ADDR_PW_FULL 16'h022F
`define PW_LEN 16'h0008
`define CRC_POLY 8'h8C
`define CRC_INIT 8'h00
`define FAMILY_CODE 8'h5A
`define SERIAL_NUM 48'h0123_4567_89AB
`endif

/* File: rtl/logger_pkg.sv */
// Types shared by both ends of the logger memory link.
package logger_pkg;
   typedef enum logic [2:0] {
      CMD_NONE = 3'h0,
      CMD_ROM_READ = 3'h1,
      CMD_ROM_OD = 3'h2,
      CMD_MEM_READ = 3'h3,
      CMD_MEM_WRITE = 3'h4,
      CMD_COPY = 3'h5
   } cmd_t;
   typedef enum logic [2:0] {
      REGION_SRAM = 3'h0,
      REGION_SIG = 3'h1,
      REGION_REG = 3'h2,
      REGION_CAL = 3'h3,
      REGION_RSV = 3'h4,
      REGION_LOG = 3'h5,
      REGION_NONE = 3'h6
   } region_t;
endpackage

/* File: rtl/logger_link_if.sv */
// Link between the logger device end and its bus master end.
`timescale 1ns/1ns
`default_nettype none
interface logger_link_if (
   input wire logic clk_sys_i,
   input wire logic rst_n_i
);
   logic req;
   logger_pkg::cmd_t cmd;
   logic [15:0] addr;
   logic [7:0] wdata;
   logic ack;
   logic [7:0] rdata;
   logic bit_valid;
   logic bit_data;
   logic od_mode;
   modport device (input req, cmd, addr, wdata, output ack, rdata, bit_valid, bit_data, od_mode);
   modport master (output req, cmd, addr, wdata, input ack, rdata, bit_valid, bit_data, od_mode);
endinterface
`default_nettype wire

/* File: rtl/logger_device.sv */
// Device end: identification code, CRC generator, memory map decode and access protection.
`include "logger_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module logger_device (
   // Clock and reset.
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Link to the master.
   logger_link_if.device link,
   // Device state.
   input wire logic mission_i,
   input wire logic battery_ok_i,
   input wire logic log_we_i,
   input wire logic [12:0] log_addr_i,
   input wire logic [7:0] log_data_i,
   output logic rom_valid_o,
   output logic [7:0] crc_o
);
   localparam logic [7:0] FAMILY = `FAMILY_CODE; // arbitrary value
   localparam logic [47:0] SERIAL = `SERIAL_NUM; // arbitrary value
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_CRC = 4'b0010,
      ST_SEND = 4'b0100,
      ST_DONE = 4'b1000
   } state_t;
   state_t state;
   logic [5:0] bit_cnt;
   logic [7:0] crc;
   logic [63:0] rom_shift;
   logic [7:0] rom_crc;
   logic selected;
   logic od;
   logic ack;
   logic [7:0] rdata;
   logic bit_valid;
   logic bit_data;
   logic [7:0] mem [0:`ADDR_CAL_HI];
   logic [7:0] logmem [0:8191];
   logic [7:0] scratch [0:31];
   logic [15:0] next_lin;
   logic crc_fb;
   logger_pkg::region_t region;

   assign link.ack = ack;
   assign link.rdata = rdata;
   assign link.bit_valid = bit_valid;
   assign link.bit_data = bit_data;
   assign link.od_mode = od;
   assign crc_o = rom_crc;

   assign crc_fb = crc[0] ^ (state == ST_CRC ? (bit_cnt < 6'd8 ? FAMILY[bit_cnt[2:0]] :
                   SERIAL[bit_cnt - 6'd8]) : 1'b0);

   // Region decode of the linear address space.
   always_comb begin
      next_lin = link.addr;
      if (next_lin <= `ADDR_SRAM_HI) begin
         region = logger_pkg::REGION_SRAM;
      end else if (next_lin <= `ADDR_SIG_HI) begin
         region = logger_pkg::REGION_SIG;
      end else if (next_lin <= `ADDR_REG_HI) begin
         region = logger_pkg::REGION_REG;
      end else if (next_lin <= `ADDR_CAL_HI) begin
         region = logger_pkg::REGION_CAL;
      end else if (next_lin <= `ADDR_RSV_HI) begin
         region = logger_pkg::REGION_RSV;
      end else if (next_lin <= `ADDR_LOG_HI) begin
         region = logger_pkg::REGION_LOG;
      end else begin
         region = logger_pkg::REGION_NONE;
      end
   end

   // Identification code build and send sequencer.
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= ST_IDLE;
         bit_cnt <= 6'h00;
         crc <= `CRC_INIT;
         rom_shift <= 64'h0;
         rom_crc <= 8'h00;
         rom_valid_o <= 1'b0;
         bit_valid <= 1'b0;
         bit_data <= 1'b0;
      end else begin
         bit_valid <= 1'b0;
         case (state)
            ST_IDLE: begin
               crc <= `CRC_INIT;
               bit_cnt <= 6'h00;
               state <= ST_CRC;
            end
            ST_CRC: begin
               crc <= (crc >> 1) ^ (crc_fb ? `CRC_POLY : 8'h00);
               bit_cnt <= bit_cnt + 6'd1;
               if (bit_cnt == 6'd55) begin
                  state <= ST_DONE;
               end
            end
            ST_DONE: begin
               rom_crc <= crc;
               rom_shift <= {crc, SERIAL, FAMILY};
               // code held on bus power alone.
               rom_valid_o <= 1'b1;
               if (link.req && (link.cmd == logger_pkg::CMD_ROM_READ ||
                   link.cmd == logger_pkg::CMD_ROM_OD)) begin
                  bit_cnt <= 6'h00;
                  state <= ST_SEND;
               end
            end
            ST_SEND: begin
               bit_valid <= 1'b1;
               bit_data <= rom_shift[0];
               rom_shift <= {1'b0, rom_shift[63:1]};
               bit_cnt <= bit_cnt + 6'd1;
               if (bit_cnt == 6'd63) begin
                  state <= ST_DONE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Selection and speed after an identification command.
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         selected <= 1'b0;
         od <= 1'b0;
      end else if (state == ST_SEND && bit_cnt == 6'd63) begin
         selected <= 1'b1;
         if (link.cmd == logger_pkg::CMD_ROM_OD) begin
            od <= 1'b1;
         end
      end
   end

   // Memory command handling.
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack <= 1'b0;
         rdata <= 8'h00;
      end else begin
         ack <= 1'b0;
         // ignore until selected.
         // Identification commands are answered by the code sequencer, never by ack.
         if (link.req && selected && !ack &&
             link.cmd != logger_pkg::CMD_ROM_READ && link.cmd != logger_pkg::CMD_ROM_OD) begin
            ack <= 1'b1;
            rdata <= 8'h00;
            case (link.cmd)
               logger_pkg::CMD_MEM_READ: begin
                  if (region == logger_pkg::REGION_LOG) begin
                     // Log index counts from the first byte of log memory.
                     rdata <= logmem[13'(link.addr - `ADDR_LOG_LO)];
                  end else if (region == logger_pkg::REGION_RSV ||
                               region == logger_pkg::REGION_NONE) begin
                     rdata <= 8'h00;
                  end else if (region == logger_pkg::REGION_REG &&
                               link.addr >= `ADDR_PW_READ &&
                               link.addr < `ADDR_PW_FULL + `PW_LEN) begin
                     rdata <= 8'h00;
                  end else begin
                     rdata <= mem[link.addr[9:0]];
                  end
               end
               default: rdata <= 8'h00;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (link.req && selected && !ack && link.cmd == logger_pkg::CMD_MEM_WRITE) begin
         scratch[link.addr[4:0]] <= link.wdata;
      end
   end

   // Copy from scratchpad into the linear space.
   always_ff @(posedge clk_sys_i) begin
      if (link.req && selected && !ack && link.cmd == logger_pkg::CMD_COPY && battery_ok_i) begin
         if (region == logger_pkg::REGION_SRAM || region == logger_pkg::REGION_SIG ||
             region == logger_pkg::REGION_CAL ||
             (region == logger_pkg::REGION_REG && !mission_i)) begin
            mem[link.addr[9:0]] <= scratch[link.addr[4:0]];
         end
      end
   end

   // log written only by control logic.
   always_ff @(posedge clk_sys_i) begin
      if (log_we_i) begin
         logmem[log_addr_i] <= log_data_i;
      end
   end
endmodule
`default_nettype wire

/* File: rtl/logger_master.sv */
// Master end: issues identification then memory commands and checks the code CRC.
`include "logger_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module logger_master (
   // Clock and reset.
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Link to the device.
   logger_link_if.master link,
   // User side.
   input wire logic start_i,
   input wire logic od_i,
   input wire logic mem_req_i,
   input wire logger_pkg::cmd_t mem_cmd_i,
   input wire logic [15:0] mem_addr_i,
   input wire logic [7:0] mem_wdata_i,
   output logic mem_done_o,
   output logic [7:0] mem_rdata_o,
   output logic rom_done_o,
   output logic crc_ok_o,
   output logic [63:0] rom_o
);
   logic req;
   logger_pkg::cmd_t cmd;
   logic [15:0] addr;
   logic [7:0] wdata;
   logic [6:0] cnt;
   logic [7:0] crc;
   logic busy;
   logic fb;

   assign link.req = req;
   assign link.cmd = cmd;
   assign link.addr = addr;
   assign link.wdata = wdata;
   // same generator on the master side.
   assign fb = crc[0] ^ link.bit_data;

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         req <= 1'b0;
         cmd <= logger_pkg::CMD_NONE;
         addr <= 16'h0000;
         wdata <= 8'h00;
         cnt <= 7'h00;
         crc <= `CRC_INIT;
         busy <= 1'b0;
         rom_done_o <= 1'b0;
         crc_ok_o <= 1'b0;
         rom_o <= 64'h0;
         mem_done_o <= 1'b0;
         mem_rdata_o <= 8'h00;
      end else begin
         mem_done_o <= 1'b0;
         if (start_i && !busy) begin
            req <= 1'b1;
            cmd <= od_i ? logger_pkg::CMD_ROM_OD : logger_pkg::CMD_ROM_READ;
            busy <= 1'b1;
            cnt <= 7'h00;
            crc <= `CRC_INIT;
            rom_done_o <= 1'b0;
         end else if (busy && link.bit_valid) begin
            req <= 1'b0;
            rom_o <= {link.bit_data, rom_o[63:1]};
            crc <= {fb, crc[7:1]} ^ (fb ? 8'h0C : 8'h00);
            cnt <= cnt + 7'd1;
            if (cnt == 7'd63) begin
               busy <= 1'b0;
               rom_done_o <= 1'b1;
               crc_ok_o <= ({fb, crc[7:1]} ^ (fb ? 8'h0C : 8'h00)) == 8'h00;
            end
         end else if (rom_done_o && mem_req_i && !req) begin
            req <= 1'b1;
            cmd <= mem_cmd_i;
            addr <= mem_addr_i;
            wdata <= mem_wdata_i;
         end else if (req && link.ack) begin
            req <= 1'b0;
            mem_done_o <= 1'b1;
            mem_rdata_o <= link.rdata;
         end
      end
   end
endmodule
`default_nettype wire

/* File: tb/logger_checker.sv */
// Assertions on the link between the logger device and master ends.
`include "logger_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module logger_checker (
   // Clock and reset.
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Link signals.
   input wire logic req,
   input wire logger_pkg::cmd_t cmd,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   input wire logic ack,
   input wire logic [7:0] rdata,
   input wire logic bit_valid,
   input wire logic bit_data,
   input wire logic od_mode
);
   logic [6:0] cnt;
   logic [7:0] crc;
   logic [63:0] bits;
   logic od_seen;
   logic rom_cmd;
   logic mem_cmd;
   logic rd_cmd;
   assign rom_cmd = req && cmd inside {logger_pkg::CMD_ROM_READ, logger_pkg::CMD_ROM_OD};
   assign rd_cmd = cmd == logger_pkg::CMD_MEM_READ;
   assign mem_cmd = rd_cmd || cmd inside {logger_pkg::CMD_MEM_WRITE, logger_pkg::CMD_COPY};
   // Rebuilds the received code and runs the CRC over all 64 bits.
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt <= 7'h00;
         crc <= 8'h00;
         bits <= 64'h0;
      end else if ($rose(rom_cmd)) begin
         cnt <= 7'h00;
         crc <= 8'h00;
      end else if (bit_valid && cnt != 7'h40) begin
         cnt <= cnt + 7'h01;
         crc <= (crc >> 1) ^ ((crc[0] ^ bit_data) ? 8'h8C : 8'h00);
         bits <= {bit_data, bits[63:1]};
      end
   end
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         od_seen <= 1'b0;
      end else if (rom_cmd && cmd == logger_pkg::CMD_ROM_OD) begin
         od_seen <= 1'b1;
      end
   end
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n_i);
   a_ack_single: assert property (ack |=> !ack)
      else $error("ack lasted more than one cycle");
   a_no_early_ack: assert property (cnt != 7'h40 |-> !ack)
      else $error("ack before a complete code read");
   a_ack_latency: assert property (cnt == 7'h40 && mem_cmd && $rose(req) |=> ack)
      else $error("memory command not answered in one cycle");
   a_req_held: assert property (req && mem_cmd && !ack |=> req && $stable(addr))
      else $error("request dropped before ack");
   a_crc_residue: assert property (cnt == 7'h40 |-> crc == 8'h00)
      else $error("code CRC residue not zero");
   a_code_fields: assert property (cnt == 7'h40 |-> bits[55:0] == {`SERIAL_NUM, `FAMILY_CODE})
      else $error("family or serial bits wrong on the link");
   a_od_cause: assert property ($rose(od_mode) |-> od_seen)
      else $error("overdrive entered without overdrive command");
   a_rsv_zero: assert property (ack && rd_cmd && addr inside {[16'h0280:16'h0FFF]}
      |=> rdata == 8'h00) else $error("reserved read not zero");
   a_pw_zero: assert property (ack && rd_cmd && addr inside {[16'h0227:16'h0236]}
      |=> rdata == 8'h00) else $error("password read back");
   c_rom_od: cover property (cnt == 7'h40 && od_mode);
   c_copy: cover property (ack && cmd == logger_pkg::CMD_COPY);
   c_rsv: cover property (ack && addr == 16'h0280);
endmodule
`default_nettype wire

/* File: tb/tb_logger_memory_map_and_rom_id.sv */
// Self-checking bench joining the logger device and master ends.
`include "logger_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_logger_memory_map_and_rom_id;
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic start_i = 1'b0;
   logic od_i = 1'b0;
   logic mem_req_i = 1'b0;
   logger_pkg::cmd_t mem_cmd_i = logger_pkg::CMD_NONE;
   logic [15:0] mem_addr_i = 16'h0000;
   logic [7:0] mem_wdata_i = 8'h00;
   logic mission_i = 1'b0;
   logic battery_ok_i = 1'b1;
   logic log_we_i = 1'b0;
   logic [12:0] log_addr_i = 13'h0000;
   logic [7:0] log_data_i = 8'h00;
   logic mem_done_o, rom_done_o, crc_ok_o, rom_valid_o;
   logic [7:0] mem_rdata_o, crc_o, rd, exp_crc;
   logic [63:0] rom_o;
   logic [15:0] ta [8] = '{16'h0000, 16'h01BF, 16'h0200, 16'h0240, 16'h027F, 16'h0280,
      16'h0FFF, 16'h0227};
   logic [7:0] te = 8'h1F;
   int mismatches = 0;
   int n_tests = 0;
   logger_link_if link (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i));
   logger_device i_logger_device (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .link(link),
      .mission_i(mission_i), .battery_ok_i(battery_ok_i), .log_we_i(log_we_i),
      .log_addr_i(log_addr_i), .log_data_i(log_data_i), .rom_valid_o(rom_valid_o), .crc_o(crc_o));
   logger_master i_logger_master (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .link(link),
      .start_i(start_i), .od_i(od_i), .mem_req_i(mem_req_i), .mem_cmd_i(mem_cmd_i),
      .mem_addr_i(mem_addr_i), .mem_wdata_i(mem_wdata_i), .mem_done_o(mem_done_o),
      .mem_rdata_o(mem_rdata_o), .rom_done_o(rom_done_o), .crc_ok_o(crc_ok_o), .rom_o(rom_o));
   logger_checker i_logger_checker (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .req(link.req),
      .cmd(link.cmd), .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata),
      .bit_valid(link.bit_valid), .bit_data(link.bit_data), .od_mode(link.od_mode));
   initial begin
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   task automatic summarize;
      $display("mismatches %0d n_tests %0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Reflected form of x^8 + x^5 + x^4 + 1, fed least significant bit first.
   function automatic logic [7:0] crc8(input logic [55:0] v);
      logic [7:0] c;
      c = 8'h00;
      for (int k = 0; k < 56; k++) c = (c >> 1) ^ ((c[0] ^ v[k]) ? 8'h8C : 8'h00);
      return c;
   endfunction
   task automatic do_reset;
      int i;
      @(negedge clk_sys_i);
      rst_n_i = 1'b0;
      repeat (8) @(negedge clk_sys_i);
      rst_n_i = 1'b1;
      for (i = 0; i < 100 && rom_valid_o !== 1'b1; i++) @(negedge clk_sys_i);
      check(64'(i < 100), 64'h1);
   endtask
   task automatic rom(input logic od);
      int i;
      @(negedge clk_sys_i);
      od_i = od;
      start_i = 1'b1;
      @(negedge clk_sys_i);
      start_i = 1'b0;
      for (i = 0; i < 200 && rom_done_o !== 1'b1; i++) @(negedge clk_sys_i);
      check(64'(i < 200), 64'h1);
      if (i == 200) summarize();
      check(rom_o, {exp_crc, `SERIAL_NUM, `FAMILY_CODE});
      check(64'(crc_o), 64'(exp_crc));
      check(64'(crc_ok_o), 64'h1);
      check(64'(link.od_mode), 64'(od));
   endtask
   // A refused request is expected to time out without completing.
   task automatic op(input logger_pkg::cmd_t c, input logic [15:0] a, input logic [7:0] d,
      input logic want);
      int i;
      @(negedge clk_sys_i);
      mem_cmd_i = c;
      mem_addr_i = a;
      mem_wdata_i = d;
      mem_req_i = 1'b1;
      for (i = 0; i < 20 && mem_done_o !== 1'b1; i++) @(negedge clk_sys_i);
      rd = mem_rdata_o;
      mem_req_i = 1'b0;
      check(64'(i < 20), 64'(want));
      if (want && i == 20) summarize();
   endtask
   task automatic put(input logic [15:0] a, input logic [7:0] d);
      op(logger_pkg::CMD_MEM_WRITE, a, d, 1'b1);
      op(logger_pkg::CMD_COPY, a, 8'h00, 1'b1);
   endtask
   task automatic get(input logic [15:0] a, input logic [7:0] e);
      op(logger_pkg::CMD_MEM_READ, a, 8'h00, 1'b1);
      check(64'(rd), 64'(e));
   endtask
   initial begin
      exp_crc = crc8({`SERIAL_NUM, `FAMILY_CODE});
      do_reset();
      op(logger_pkg::CMD_MEM_READ, 16'h0000, 8'h00, 1'b0);
      do_reset();
      rom(1'b0);
      for (int k = 0; k < 8; k++) begin
         put(ta[k], 8'hA5 ^ ta[k][7:0]);
         get(ta[k], te[k] ? 8'hA5 ^ ta[k][7:0] : 8'h00);
      end
      put(16'h0201, 8'h11);
      mission_i = 1'b1;
      put(16'h0201, 8'h66);
      get(16'h0201, 8'h11);
      mission_i = 1'b0;
      battery_ok_i = 1'b0;
      put(16'h0000, 8'h77);
      get(16'h0000, 8'hA5);
      battery_ok_i = 1'b1;
      for (int k = 0; k < 2; k++) begin
         @(negedge clk_sys_i);
         log_we_i = 1'b1;
         log_addr_i = k ? 13'h1FFF : 13'h0000;
         log_data_i = 8'h3C ^ 8'(k);
         @(negedge clk_sys_i);
         log_we_i = 1'b0;
         put(k ? 16'h2FFF : 16'h1000, 8'hC3);
         get(k ? 16'h2FFF : 16'h1000, 8'h3C ^ 8'(k));
      end
      do_reset();
      rom(1'b1);
      get(16'h0280, 8'h00);
      summarize();
   end
endmodule
`default_nettype wire
